// ---- logic/wdt_pkg.sv ----
package wdt_pkg;
    localparam int CNT_W = 24;
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_TC = 8'h04;
    localparam logic [7:0] OFF_FEED = 8'h08;
    localparam logic [7:0] OFF_TV = 8'h0C;
    localparam logic [7:0] OFF_WARN = 8'h14;
    localparam logic [7:0] OFF_WIN = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1C;
    localparam logic [7:0] OFF_MASK = 8'h20;
    localparam int MODE_RUN = 0;
    localparam int MODE_RST = 1;
    localparam int MODE_PROT = 2;
    localparam int MODE_LOCK = 3;
    localparam int ST_TO = 0;
    localparam int ST_WARN = 1;
    localparam logic [23:0] TC_MIN = 24'h00_00FF;
    localparam logic [23:0] TC_RST = 24'hFF_FFFF;
    localparam logic [23:0] WIN_RST = 24'hFF_FFFF;
    localparam logic [23:0] WARN_RST = 24'h00_0000;
    localparam logic [7:0] FEED_KEY1 = 8'hAA;
    localparam logic [7:0] FEED_KEY2 = 8'h55;
    localparam int TICK_DIV = 4;
    typedef enum logic [1:0] {
        FEED_IDLE = 2'b00,
        FEED_HALF = 2'b01
    } feed_t;
endpackage

// ---- logic/wd_tick_gen.sv ----
`timescale 1ns/1ps
// divides the synchronised watchdog clock edges by four
module wd_tick_gen (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic edge_i,
    output logic tick_o
);
    import wdt_pkg::*;
    logic [1:0] div_r;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_r <= 2'h0;
            tick_o <= 1'b0;
        end else if (en_i) begin
            tick_o <= 1'b0;
            if (edge_i) begin
                div_r <= div_r + 2'h1;
                tick_o <= (div_r == 2'(TICK_DIV - 1));
            end
        end
    end
endmodule

// ---- logic/windowed_watchdog_timer.sv ----
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module windowed_watchdog_timer (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic CLK_EN_I,
    input wire logic WD_TICK_CLOCK_I,
    input wire logic OSC_OFF_REQ_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic IRQ_O,
    output logic CHIP_RESET_O,
    output logic OSC_OFF_O
);
    import wdt_pkg::*;

    logic [2:0] clk_sync_r;
    logic tick;
    logic wd_edge;
    logic [CNT_W-1:0] counter_value_r;
    logic [CNT_W-1:0] timeout_constant_r;
    logic [CNT_W-1:0] warning_compare_value_r;
    logic [CNT_W-1:0] window_r;
    logic wd_run_enable_r;
    logic timeout_reset_enable_r;
    logic timeout_change_protect_r;
    logic oscillator_lock_r;
    logic running_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [1:0] clr_pend_r;
    feed_t feed_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic wr_go;
    logic rd_go;
    logic feed_ok;
    logic key1_write;
    logic key2_write;
    logic mode_write;
    logic warn_write;
    logic win_write;
    logic stat_write;
    logic mask_write;
    logic feed_write;
    logic tc_write;
    logic tc_violation;
    logic window_violation;
    logic timeout_hit;
    logic wd_event;
    logic warn_cond_r;
    logic [23:0] wdata24;
    logic [31:0] rd_word;
    logic [1:0] flag_set;
    logic [1:0] status_nxt;
    logic counter_zero;
    logic count_step;
    logic warn_hit;
    logic below_both;

    // pin clock: two flops before use, the third only feeds the edge detector
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            clk_sync_r <= 3'h0;
        end else if (CLK_EN_I) begin
            clk_sync_r <= {clk_sync_r[1:0], WD_TICK_CLOCK_I};
        end
    end
    assign wd_edge = clk_sync_r[1] & ~clk_sync_r[2];

    // divider in its own module keeps its phase across feeds
    wd_tick_gen u_tick (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .en_i(CLK_EN_I),
        .edge_i(wd_edge),
        .tick_o(tick)
    );

    // ahb-lite slave, zero wait states, writes applied after the data phase
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (CLK_EN_I) begin
            if (HREADY_I) begin
                wr_pend_r <= HSEL_I & HTRANS_I[1] & HWRITE_I;
                wr_addr_r <= HADDR_I[7:0];
            end
        end
    end
    assign wr_go = wr_pend_r;
    assign rd_go = HREADY_I & HSEL_I & HTRANS_I[1] & ~HWRITE_I;
    assign wdata24 = HWDATA_I[23:0];
    assign tc_write = wr_go && (wr_addr_r == OFF_TC);
    assign mode_write = wr_go && (wr_addr_r == OFF_MODE);
    assign warn_write = wr_go && (wr_addr_r == OFF_WARN);
    assign win_write = wr_go && (wr_addr_r == OFF_WIN);
    assign stat_write = wr_go && (wr_addr_r == OFF_STAT);
    assign mask_write = wr_go && (wr_addr_r == OFF_MASK);
    assign feed_write = wr_go && (wr_addr_r == OFF_FEED);
    assign key1_write = feed_write && (HWDATA_I[7:0] == FEED_KEY1);
    assign key2_write = feed_write && (HWDATA_I[7:0] == FEED_KEY2);

    // read decode kept apart so the bus flops stay plain
    always_comb begin
        case (HADDR_I[7:0])
            OFF_MODE: rd_word = {28'h000_0000, oscillator_lock_r, timeout_change_protect_r,
                                 timeout_reset_enable_r, wd_run_enable_r};
            OFF_TC: rd_word = {8'h00, timeout_constant_r};
            OFF_TV: rd_word = {8'h00, counter_value_r};
            OFF_WARN: rd_word = {8'h00, warning_compare_value_r};
            OFF_WIN: rd_word = {8'h00, window_r};
            OFF_STAT: rd_word = {30'h0000_0000, status_r};
            OFF_MASK: rd_word = {30'h0000_0000, mask_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // zero wait states and never an error, so both stay fixed after reset
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else if (CLK_EN_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (CLK_EN_I && rd_go) begin
            // counter read has no side effect on the count
            HRDATA_O <= rd_word;
        end
    end

    // mode bits are set-only; lock and run never clear by software
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            wd_run_enable_r <= 1'b0;
        end else if (CLK_EN_I && mode_write) begin
            wd_run_enable_r <= wd_run_enable_r | HWDATA_I[MODE_RUN];
        end
    end

    // reset enable is sticky too, so a rogue write cannot defuse the dog
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            timeout_reset_enable_r <= 1'b0;
        end else if (CLK_EN_I && mode_write) begin
            timeout_reset_enable_r <= timeout_reset_enable_r | HWDATA_I[MODE_RST];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            timeout_change_protect_r <= 1'b0;
        end else if (CLK_EN_I && mode_write) begin
            timeout_change_protect_r <= timeout_change_protect_r | HWDATA_I[MODE_PROT];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            oscillator_lock_r <= 1'b0;
        end else if (CLK_EN_I && mode_write) begin
            oscillator_lock_r <= oscillator_lock_r | HWDATA_I[MODE_LOCK];
        end
    end

    // lock only gates the request; the oscillator itself lives outside
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            OSC_OFF_O <= 1'b0;
        end else if (CLK_EN_I) begin
            OSC_OFF_O <= OSC_OFF_REQ_I & ~oscillator_lock_r;
        end
    end

    // values under the floor are raised, not refused
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            timeout_constant_r <= TC_RST;
        end else if (CLK_EN_I && tc_write) begin
            timeout_constant_r <= (wdata24 < TC_MIN) ? TC_MIN : wdata24;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            warning_compare_value_r <= WARN_RST;
        end else if (CLK_EN_I && warn_write) begin
            warning_compare_value_r <= wdata24;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            window_r <= WIN_RST;
        end else if (CLK_EN_I && win_write) begin
            window_r <= wdata24;
        end
    end

    // feed: key1 then key2 on consecutive writes; any other write except a repeated key1 breaks it
    assign feed_ok = key2_write && (feed_r == FEED_HALF);
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            feed_r <= FEED_IDLE;
        end else if (CLK_EN_I && wr_go) begin
            case (feed_r)
                FEED_IDLE: feed_r <= key1_write ? FEED_HALF : FEED_IDLE;
                FEED_HALF: feed_r <= key1_write ? FEED_HALF : FEED_IDLE;
                default: feed_r <= FEED_IDLE;
            endcase
        end
    end

    // window of all ones can never be exceeded, so feeds stay free
    assign window_violation = feed_ok && running_r && (counter_value_r > window_r);
    assign below_both = counter_value_r < warning_compare_value_r && counter_value_r < window_r;
    assign tc_violation = tc_write && timeout_change_protect_r && !below_both;
    // counter parks at zero, so an unfed dog repeats the event every tick
    assign counter_zero = (counter_value_r == 24'h00_0000);
    assign timeout_hit = running_r && tick && counter_zero;
    assign count_step = running_r && tick && !counter_zero;
    assign wd_event = timeout_hit | window_violation | tc_violation;

    // once running there is no way back short of a chip reset
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            running_r <= 1'b0;
        end else if (CLK_EN_I && feed_ok && wd_run_enable_r) begin
            running_r <= 1'b1;
        end
    end

    // a feed outranks a tick landing in the same cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            counter_value_r <= TC_RST;
        end else if (CLK_EN_I) begin
            if (feed_ok) begin
                counter_value_r <= timeout_constant_r;
            end else if (count_step) begin
                counter_value_r <= counter_value_r - 24'h00_0001;
            end
        end
    end

    // warning compare sampled on a watchdog clock, seen on the next one
    assign warn_hit = running_r && warning_compare_value_r != 24'h00_0000 &&
                      counter_value_r <= warning_compare_value_r;
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            warn_cond_r <= 1'b0;
        end else if (CLK_EN_I && wd_edge) begin
            warn_cond_r <= warn_hit;
        end
    end

    // clears latched and applied at the next watchdog clock
    // a clear written on the edge itself is kept for the following one
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            clr_pend_r <= 2'b00;
        end else if (CLK_EN_I) begin
            if (wd_edge) begin
                clr_pend_r <= stat_write ? HWDATA_I[1:0] : 2'b00;
            end else if (stat_write) begin
                clr_pend_r <= clr_pend_r | HWDATA_I[1:0];
            end
        end
    end

    // set wins over a clear landing on the same edge
    assign flag_set[ST_TO] = wd_event;
    assign flag_set[ST_WARN] = wd_edge & warn_cond_r;
    for (genvar i = 0; i < 2; i++) begin : g_flag
        assign status_nxt[i] = (status_r[i] & ~(wd_edge & clr_pend_r[i])) | flag_set[i];
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            status_r <= 2'b00;
        end else if (CLK_EN_I) begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            mask_r <= 2'b00;
        end else if (CLK_EN_I && mask_write) begin
            mask_r <= HWDATA_I[1:0];
        end
    end

    // mask only gates the line, never the flags
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
        end else if (CLK_EN_I) begin
            IRQ_O <= |(status_r & mask_r);
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            CHIP_RESET_O <= 1'b0;
        end else if (CLK_EN_I) begin
            // one pulse per event; the chip reset tree stretches it as needed
            CHIP_RESET_O <= wd_event & timeout_reset_enable_r;
        end
    end
endmodule

// ---- bench/wdt_properties.sv ----
`timescale 1ns/1ps
module wdt_checker
import wdt_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic OSC_OFF_REQ_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic IRQ_O,
    input wire logic CHIP_RESET_O,
    input wire logic OSC_OFF_O
);
    logic dp_r, wr_r;
    logic [7:0] ad_r;
    logic [3:0] mode_r;
    logic [1:0] mask_r;
    logic rd_mode, rd_tc;
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            dp_r <= 1'b0;
        end else if (HREADY_I) begin
            dp_r <= HSEL_I && HTRANS_I[1];
            wr_r <= HWRITE_I;
            ad_r <= HADDR_I[7:0];
        end
    end
    // shadow of software-visible settings, mode bits only accumulate
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            mode_r <= 4'h0;
            mask_r <= 2'b00;
        end else if (dp_r && wr_r && HREADY_I) begin
            if (ad_r == OFF_MODE) mode_r <= mode_r | HWDATA_I[3:0];
            if (ad_r == OFF_MASK) mask_r <= HWDATA_I[1:0];
        end
    end
    assign rd_mode = dp_r && !wr_r && ad_r == OFF_MODE;
    assign rd_tc = dp_r && !wr_r && ad_r == OFF_TC;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_upper_bits_zero: assert property (HRDATA_O[31:24] == 8'h00)
        else $error("read data above bit 23 not zero");
    a_mode_bits_sticky: assert property (rd_mode |-> (HRDATA_O[3:0] & $past(mode_r)) == $past(mode_r))
        else $error("mode bit lost");
    a_tc_floor: assert property (rd_tc |-> HRDATA_O[23:0] >= TC_MIN)
        else $error("timeout constant below floor");
    a_osc_lock_holds: assert property ($past(mode_r[MODE_LOCK]) |-> !OSC_OFF_O)
        else $error("oscillator off while locked");
    a_osc_req_follow: assert property (!$past(mode_r[MODE_LOCK]) && $past(RST_N_I)
        |-> OSC_OFF_O == $past(OSC_OFF_REQ_I))
        else $error("oscillator off does not follow request");
    a_reset_gated: assert property (!$past(mode_r[MODE_RST]) |-> !CHIP_RESET_O)
        else $error("chip reset without reset enable");
    a_reset_one_cycle: assert property (CHIP_RESET_O |=> !CHIP_RESET_O)
        else $error("chip reset longer than one cycle");
    a_irq_masked: assert property ($past(mask_r) == 2'b00 |-> !IRQ_O)
        else $error("interrupt while all masked");
endmodule
bind windowed_watchdog_timer wdt_checker chk (.SYS_CLK_I, .RST_N_I, .HSEL_I, .HADDR_I, .HTRANS_I,
    .HWRITE_I, .HWDATA_I, .HREADY_I, .OSC_OFF_REQ_I, .HRDATA_O, .IRQ_O, .CHIP_RESET_O, .OSC_OFF_O);

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import wdt_pkg::*;
    logic clk, rst_n, cen, wdc, oreq, hsel, hwrite, ready, resp, irq, crst, osc;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    int miscompares = 0;
    int checks_done = 0;
    int pulses = 0;
    windowed_watchdog_timer uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(cen), .WD_TICK_CLOCK_I(wdc),
        .OSC_OFF_REQ_I(oreq), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(ready), .HRDATA_O(hrdata), .HREADYOUT_O(ready),
        .HRESP_O(resp), .IRQ_O(irq), .CHIP_RESET_O(crst), .OSC_OFF_O(osc));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (crst === 1'b1) pulses <= pulses + 1;
    task wrap_up;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // bounded wait for hready; ready low forever would hang the bus
    task hwait;
        int n;
        n = 0;
        @(posedge clk);
        while (ready !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                wrap_up;
            end
            @(posedge clk);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        hwait;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hwait;
        rd_q = hrdata;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0000_0000);
        chk(n, e, rd_q);
    endtask
    task feed;
        xfer(1'b1, OFF_FEED, {24'h00_0000, FEED_KEY1});
        xfer(1'b1, OFF_FEED, {24'h00_0000, FEED_KEY2});
    endtask
    // whole periods of the watchdog clock, 8 system cycles each
    task wd(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            wdc <= 1'b1;
            repeat (4) @(posedge clk);
            wdc <= 1'b0;
        end
    endtask
    initial begin
        {rst_n, wdc, oreq, hsel, hwrite, htrans, haddr, hwdata} = '0;
        cen = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        oreq <= 1'b1;
        rc(OFF_TC, 32'h00FF_FFFF, "tc");
        chk("hresp", 32'h0000_0000, {31'h0, resp});
        rc(OFF_WIN, 32'h00FF_FFFF, "win");
        rc(OFF_TV, 32'h00FF_FFFF, "tv");
        rc(8'h40, 32'h0000_0000, "unmapped");
        chk("osc", 32'h0000_0001, {31'h0, osc});
        xfer(1'b1, OFF_TC, 32'h0000_0010);
        rc(OFF_TC, 32'h0000_00FF, "tc_min");
        xfer(1'b1, OFF_MODE, 32'h0000_0003);
        xfer(1'b1, OFF_MODE, 32'h0000_0000);
        rc(OFF_MODE, 32'h0000_0003, "mode");
        xfer(1'b1, OFF_MASK, 32'h0000_0003);
        feed;
        rc(OFF_TV, 32'h0000_00FF, "tv_feed");
        xfer(1'b1, OFF_WARN, 32'h0000_00F0);
        wd(32);
        rc(OFF_TV, 32'h0000_00F7, "tv_step");
        rc(OFF_STAT, 32'h0000_0000, "warn_early");
        wd(48);
        rc(OFF_STAT, 32'h0000_0002, "warn_flag");
        chk("irq", 32'h0000_0001, {31'h0, irq});
        xfer(1'b1, OFF_WARN, 32'h0000_0000);
        // one watchdog clock lets the last pending warning land before the clear
        wd(1);
        xfer(1'b1, OFF_STAT, 32'h0000_0002);
        wd(3);
        rc(OFF_STAT, 32'h0000_0000, "warn_clr");
        rc(OFF_TV, 32'h0000_00EA, "tv_keep");
        xfer(1'b1, OFF_WIN, 32'h0000_0080);
        feed;
        wd(4);
        rc(OFF_STAT, 32'h0000_0001, "win_evt");
        chk("pulses", 32'h0000_0001, pulses);
        xfer(1'b1, OFF_STAT, 32'h0000_0001);
        wd(4);
        rc(OFF_STAT, 32'h0000_0000, "to_clr");
        xfer(1'b1, OFF_WIN, 32'h00FF_FFFF);
        feed;
        wd(4);
        rc(OFF_STAT, 32'h0000_0000, "win_off");
        xfer(1'b1, OFF_FEED, {24'h00_0000, FEED_KEY1});
        xfer(1'b1, OFF_WARN, 32'h0000_0000);
        xfer(1'b1, OFF_FEED, {24'h00_0000, FEED_KEY2});
        rc(OFF_TV, 32'h0000_00FE, "bad_feed");
        // clock enable low: watchdog clocks pass unseen and the count stands
        cen <= 1'b0;
        wd(4);
        cen <= 1'b1;
        rc(OFF_TV, 32'h0000_00FE, "tv_frozen");
        xfer(1'b1, OFF_MODE, 32'h0000_0004);
        xfer(1'b1, OFF_TC, 32'h0000_0100);
        wd(4);
        rc(OFF_STAT, 32'h0000_0001, "prot_evt");
        chk("pulses", 32'h0000_0002, pulses);
        xfer(1'b1, OFF_STAT, 32'h0000_0001);
        feed;
        wd(1028);
        rc(OFF_STAT, 32'h0000_0001, "timeout");
        chk("pulses", 32'h0000_0003, pulses);
        xfer(1'b1, OFF_MODE, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk("osc_lock", 32'h0000_0000, {31'h0, osc});
        wrap_up;
    end
endmodule
